// ==== eiec_pkg.sv ====
// Register map, field layout and reset values of the external interrupt front end
package eiec_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_REGS        = 7;
    // Byte offsets
    localparam logic [7:0]  OFS_EDGE_NMI    = 8'h00;
    localparam logic [7:0]  OFS_EDGE_WAKE   = 8'h04;
    localparam logic [7:0]  OFS_INT_EN      = 8'h08;
    localparam logic [7:0]  OFS_REQ_FLAGS   = 8'h0C;
    localparam logic [7:0]  OFS_WAKE_FLAGS  = 8'h10;
    localparam logic [7:0]  OFS_EVT_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_EVT_MASK    = 8'h18;
    // Field positions
    localparam int          NMI_EDGE_BIT    = 7;
    localparam int          DT_EN_BIT       = 7;
    localparam int          WAKE_EN_BIT     = 5;
    localparam int          DT_FLAG_BIT     = 7;
    localparam int          EVT_WAKE_BIT    = 4;
    localparam int          EVT_DT_BIT      = 5;
    localparam int          EVT_NMI_BIT     = 6;
    localparam int          NUM_EXT         = 4;
    localparam int          NUM_WAKE        = 6;
    // Writable bits and constant read bits
    localparam logic [7:0]  EDGE_NMI_WMASK  = 8'h8F;
    localparam logic [7:0]  EDGE_NMI_ONES   = 8'h70;
    localparam logic [7:0]  EDGE_WAKE_WMASK = 8'h3F;
    localparam logic [7:0]  EDGE_WAKE_ONES  = 8'hC0;
    localparam logic [7:0]  INT_EN_WMASK    = 8'hAF;
    localparam logic [7:0]  INT_EN_ONES     = 8'h10;
    localparam logic [7:0]  REQ_FLAGS_MASK  = 8'h8F;
    localparam logic [7:0]  WAKE_FLAGS_MASK = 8'h3F;
    localparam logic [7:0]  EVT_MASK        = 8'h7F;
    // Reset values of the stored bits
    localparam logic [7:0]  EDGE_RST        = 8'h00;
    localparam logic [7:0]  EN_RST          = 8'h00;
    localparam logic [7:0]  FLAG_RST        = 8'h00;

    // Word index of a byte address, and whether a register lives there
    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
        return addr[4:2];
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        return (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] < NUM_REGS);
    endfunction
endpackage

// ==== eiec_if.sv ====
// Carriers between the top module and its edge bank and bus front end
`timescale 1ns/1ps
interface eiec_edge_if #(parameter int N = 11);
    logic [N-1:0] pin;
    logic [N-1:0] rise_sel;
    logic [N-1:0] hit;
    modport ctrl (output pin, output rise_sel, input hit);
    modport det  (input pin, input rise_sel, output hit);
endinterface

interface eiec_reg_if;
    logic        wr_stb;
    logic        rd_done;
    logic [2:0]  idx;
    logic [7:0]  wdata;
    logic [7:0]  rd_mux;
    modport slv  (output wr_stb, output rd_done, output idx, output wdata, input rd_mux);
    modport regs (input wr_stb, input rd_done, input idx, input wdata, output rd_mux);
endinterface

// ==== eiec_edge_det.sv ====
// Synchronised edge detectors with a per-pin rising/falling select
`timescale 1ns/1ps
module eiec_edge_det
    import eiec_pkg::*;
#(
    parameter int N = 11
) (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   rst_sync_n,
    // Pins, selects and hits
    eiec_edge_if.det    edg
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] hit_q;

    // Refused at elaboration: the bank needs at least one pin
    if (N < 1) begin : g_bad_n
        $error("eiec_edge_det needs at least one pin");
    end

    // Pins idle high, so the chain starts high to avoid a false falling edge
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= edg.pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Compare synchronised level across consecutive cycles
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hit_q <= '0;
        end else begin
            hit_q <= (edg.rise_sel & sync_q & ~prev_q)
                   | (~edg.rise_sel & ~sync_q & prev_q);
        end
    end

    assign edg.hit = hit_q;
endmodule

// ==== eiec_apb_slv.sv ====
// APB slave front end: decode, read data register and error answer
`timescale 1ns/1ps
module eiec_apb_slv
    import eiec_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst_sync_n,
    // APB
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Register side
    eiec_reg_if.slv                  rb
);
    logic [7:0] prdata_q;
    logic       mapped;
    logic       access;

    assign mapped     = reg_mapped(paddr);
    assign access     = psel & penable;
    assign pready     = 1'b1;
    assign pslverr    = access & ~mapped;
    assign rb.idx     = reg_index(paddr);
    assign rb.wdata   = pwdata[7:0];
    assign rb.wr_stb  = access & pwrite & mapped;
    assign rb.rd_done = access & ~pwrite & mapped;
    assign prdata     = {{(DATA_W-8){1'b0}}, prdata_q};

    // Read data is caught in the setup cycle so the access phase needs no wait
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata_q <= 8'h00;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= mapped ? rb.rd_mux : 8'h00;
        end
    end
endmodule

// ==== eiec_top.sv ====
// External interrupt front end: edge selects, enables, request flags and CPU requests
`timescale 1ns/1ps
// What this block does
// - NMI edge select bit7, falling by default
// - Four request pins, per-pin edge select bits
// - Six wakeup pins edge select; pin5 triggers ADC
// - Unused edge register bits read as one
// - Enable bit6 reads zero, bit4 reads one
// - Direct-transition request only when its enable set
// - One common enable for all wakeup pins
// - Request pin interrupts gated by own enables
// - Request coinciding with clear is still taken
// - Flag set on chosen edge in interrupt mode
// - CPU mask bit blocks maskable external requests
module eiec_top
    import eiec_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // APB
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // External pins
    input  wire logic                nmi_pin,
    input  wire logic [NUM_EXT-1:0]  ext_req_pin,
    input  wire logic [NUM_EXT-1:0]  ext_req_pin_irq_mode,
    input  wire logic [NUM_WAKE-1:0] wake_pin,
    // CPU side
    input  wire logic                cpu_irq_mask,
    input  wire logic                direct_transition_evt,
    output logic                     nmi_req,
    output logic [NUM_EXT-1:0]       ext_req_cpu,
    output logic                     wakeup_req_cpu,
    output logic                     direct_transition_req_cpu,
    output logic                     adc_ext_trigger,
    output logic                     irq
);
    localparam int NPIN = 1 + NUM_EXT + NUM_WAKE;

    logic       rst_meta_q;
    logic       rst_sync_n;
    logic [7:0] edge_nmi_q;
    logic [7:0] edge_wake_q;
    logic [7:0] int_en_q;
    logic [7:0] req_flags_q;
    logic [7:0] req_flags_d;
    logic [7:0] wake_flags_q;
    logic [7:0] wake_flags_d;
    logic [7:0] evt_status_q;
    logic [7:0] evt_status_d;
    logic [7:0] evt_mask_q;
    logic [7:0] evt_set;
    logic [7:0] req_set;
    logic [7:0] wake_set;
    logic       nmi_hit;
    logic [NUM_EXT-1:0]  ext_hit;
    logic [NUM_WAKE-1:0] wake_hit;
    logic                nmi_req_q;
    logic [NUM_EXT-1:0]  ext_req_cpu_q;
    logic                wakeup_req_cpu_q;
    logic                dt_req_cpu_q;
    logic                adc_trig_q;
    logic                irq_q;

    eiec_edge_if #(.N(NPIN)) edg ();
    eiec_reg_if              rb ();

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    eiec_apb_slv u_apb (
        .clock      (clock),
        .rst_sync_n (rst_sync_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .rb         (rb)
    );

    // Bit 0 is the NMI pin, then request pins, then wakeup pins
    assign edg.pin      = {wake_pin, ext_req_pin, nmi_pin};
    assign edg.rise_sel = {edge_wake_q[NUM_WAKE-1:0],
                           edge_nmi_q[NUM_EXT-1:0],
                           edge_nmi_q[NMI_EDGE_BIT]};

    eiec_edge_det #(.N(NPIN)) u_edge (
        .clock      (clock),
        .rst_sync_n (rst_sync_n),
        .edg        (edg)
    );

    assign nmi_hit  = edg.hit[0];
    assign ext_hit  = edg.hit[NUM_EXT:1];
    assign wake_hit = edg.hit[NPIN-1:NUM_EXT+1];

    function automatic logic wr_to(input logic [7:0] ofs);
        return rb.wr_stb && (rb.idx == reg_index(ofs));
    endfunction

    function automatic logic rd_of(input logic [7:0] ofs);
        return rb.rd_done && (rb.idx == reg_index(ofs));
    endfunction

    // Edge select registers
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            edge_nmi_q  <= EDGE_RST;
            edge_wake_q <= EDGE_RST;
        end else begin
            if (wr_to(OFS_EDGE_NMI)) begin
                edge_nmi_q <= rb.wdata & EDGE_NMI_WMASK;
            end
            if (wr_to(OFS_EDGE_WAKE)) begin
                edge_wake_q <= rb.wdata & EDGE_WAKE_WMASK;
            end
        end
    end

    // Enable register
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_en_q <= EN_RST;
        end else if (wr_to(OFS_INT_EN)) begin
            int_en_q <= rb.wdata & INT_EN_WMASK;
        end
    end

    // Request flags: a set in the same cycle as a write-0 clear wins
    always_comb begin
        req_set                    = 8'h00;
        req_set[NUM_EXT-1:0]       = ext_hit & ext_req_pin_irq_mode;
        req_set[DT_FLAG_BIT]       = direct_transition_evt;
        wake_set                   = {2'b00, wake_hit};
        req_flags_d  = req_flags_q;
        wake_flags_d = wake_flags_q;
        if (wr_to(OFS_REQ_FLAGS)) begin
            req_flags_d = req_flags_q & rb.wdata;
        end
        if (wr_to(OFS_WAKE_FLAGS)) begin
            wake_flags_d = wake_flags_q & rb.wdata;
        end
        req_flags_d  = (req_flags_d | req_set) & REQ_FLAGS_MASK;
        wake_flags_d = (wake_flags_d | wake_set) & WAKE_FLAGS_MASK;
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_flags_q  <= FLAG_RST;
            wake_flags_q <= FLAG_RST;
        end else begin
            req_flags_q  <= req_flags_d;
            wake_flags_q <= wake_flags_d;
        end
    end

    // Sticky event status, cleared by reading it; a new event wins over the clear.
    // Only bits shown in the captured read data are cleared, so an event that lands
    // on the setup edge of the read is kept for the next read instead of being lost.
    always_comb begin
        evt_set                    = 8'h00;
        evt_set[NUM_EXT-1:0]       = req_set[NUM_EXT-1:0];
        evt_set[EVT_WAKE_BIT]      = |wake_hit;
        evt_set[EVT_DT_BIT]        = direct_transition_evt;
        evt_set[EVT_NMI_BIT]       = nmi_hit;
        evt_status_d = rd_of(OFS_EVT_STATUS) ? (evt_status_q & ~prdata[7:0]) : evt_status_q;
        evt_status_d = (evt_status_d | evt_set) & EVT_MASK;
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            evt_status_q <= FLAG_RST;
            evt_mask_q   <= FLAG_RST;
        end else begin
            evt_status_q <= evt_status_d;
            if (wr_to(OFS_EVT_MASK)) begin
                evt_mask_q <= rb.wdata & EVT_MASK;
            end
        end
    end

    // Read mux; reserved bits return their fixed levels whatever was written
    always_comb begin
        case (rb.idx)
            reg_index(OFS_EDGE_NMI):   rb.rd_mux = edge_nmi_q | EDGE_NMI_ONES;
            reg_index(OFS_EDGE_WAKE):  rb.rd_mux = edge_wake_q | EDGE_WAKE_ONES;
            reg_index(OFS_INT_EN):     rb.rd_mux = int_en_q | INT_EN_ONES;
            reg_index(OFS_REQ_FLAGS):  rb.rd_mux = req_flags_q;
            reg_index(OFS_WAKE_FLAGS): rb.rd_mux = wake_flags_q;
            reg_index(OFS_EVT_STATUS): rb.rd_mux = evt_status_q;
            reg_index(OFS_EVT_MASK):   rb.rd_mux = evt_mask_q;
            default:                   rb.rd_mux = 8'h00;
        endcase
    end

    // CPU requests; the mask bit holds a pending flag back rather than dropping it
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_req_cpu_q    <= '0;
            wakeup_req_cpu_q <= 1'b0;
            dt_req_cpu_q     <= 1'b0;
        end else begin
            ext_req_cpu_q    <= req_flags_q[NUM_EXT-1:0] & int_en_q[NUM_EXT-1:0]
                              & {NUM_EXT{~cpu_irq_mask}};
            wakeup_req_cpu_q <= (|wake_flags_q[NUM_WAKE-1:0]) & int_en_q[WAKE_EN_BIT]
                              & ~cpu_irq_mask;
            dt_req_cpu_q     <= req_flags_q[DT_FLAG_BIT] & int_en_q[DT_EN_BIT]
                              & ~cpu_irq_mask;
        end
    end

    // NMI ignores the CPU mask; pin 5 also feeds the converter trigger
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            nmi_req_q  <= 1'b0;
            adc_trig_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            nmi_req_q  <= nmi_hit;
            adc_trig_q <= wake_hit[NUM_WAKE-1];
            irq_q      <= |(evt_status_q & evt_mask_q);
        end
    end

    assign nmi_req                   = nmi_req_q;
    assign ext_req_cpu               = ext_req_cpu_q;
    assign wakeup_req_cpu            = wakeup_req_cpu_q;
    assign direct_transition_req_cpu = dt_req_cpu_q;
    assign adc_ext_trigger           = adc_trig_q;
    assign irq                       = irq_q;
endmodule

// ==== eiec_unused_placeholder_guard.sv ====
// Empty on purpose: no additional logic
`timescale 1ns/1ps

// ==== eiec_checker.sv ====
// Port-level assertions for the external interrupt front end
`timescale 1ns/1ps
module eiec_checker
    import eiec_pkg::*;
(
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst_n,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [DATA_W-1:0]   pwdata,
    input wire logic [DATA_W-1:0]   prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Pins
    input wire logic                nmi_pin,
    input wire logic [NUM_EXT-1:0]  ext_req_pin,
    input wire logic [NUM_EXT-1:0]  ext_req_pin_irq_mode,
    input wire logic [NUM_WAKE-1:0] wake_pin,
    // CPU side
    input wire logic                cpu_irq_mask,
    input wire logic                direct_transition_evt,
    input wire logic                nmi_req,
    input wire logic [NUM_EXT-1:0]  ext_req_cpu,
    input wire logic                wakeup_req_cpu,
    input wire logic                direct_transition_req_cpu,
    input wire logic                adc_ext_trigger,
    input wire logic                irq
);
    logic       nmi_prev_q;
    logic       wk5_prev_q;
    logic [3:0] nmi_age_q;
    logic [3:0] wk5_age_q;
    // Cycles since the NMI pin and wakeup pin 5 last moved; saturates so an idle pin never wraps
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_q <= 1'b1;
            nmi_age_q  <= 4'hF;
        end else begin
            nmi_prev_q <= nmi_pin;
            nmi_age_q  <= (nmi_pin != nmi_prev_q) ? 4'h0 : nmi_age_q + {3'h0, nmi_age_q != 4'hF};
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wk5_prev_q <= 1'b1;
            wk5_age_q  <= 4'hF;
        end else begin
            wk5_prev_q <= wake_pin[5];
            wk5_age_q  <= (wake_pin[5] != wk5_prev_q) ? 4'h0 : wk5_age_q + {3'h0, wk5_age_q != 4'hF};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_acc(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    ready_high_a: assert property (pready)
        else $error("pready low");
    err_decode_a: assert property (pslverr == (psel && penable && (paddr[1:0] != 2'h0 || paddr >= 8'h1C)))
        else $error("pslverr does not match the address decode");
    rd_edge_nmi_a: assert property (rd_acc(OFS_EDGE_NMI) |-> prdata[6:4] == 3'h7)
        else $error("spare bits of first edge register not one");
    rd_edge_wake_a: assert property (rd_acc(OFS_EDGE_WAKE) |-> prdata[7:6] == 2'h3)
        else $error("spare bits of second edge register not one");
    rd_int_en_a: assert property (rd_acc(OFS_INT_EN) |-> !prdata[6] && prdata[4])
        else $error("reserved enable bits read wrong");
    nmi_pulse_a: assert property (nmi_req |=> !nmi_req)
        else $error("nmi request longer than one cycle");
    adc_pulse_a: assert property (adc_ext_trigger |=> !adc_ext_trigger)
        else $error("adc trigger longer than one cycle");
    nmi_cause_a: assert property (nmi_req |-> nmi_age_q inside {[1:5]})
        else $error("nmi request without a recent pin edge");
    adc_cause_a: assert property (adc_ext_trigger |-> wk5_age_q inside {[1:5]})
        else $error("adc trigger without a recent pin edge");
    mask_block_a: assert property ($past(cpu_irq_mask) |-> ext_req_cpu == 4'h0 && !wakeup_req_cpu
        && !direct_transition_req_cpu) else $error("maskable request while masked");
endmodule

bind eiec_top eiec_checker u_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_pin(nmi_pin), .ext_req_pin(ext_req_pin),
    .ext_req_pin_irq_mode(ext_req_pin_irq_mode), .wake_pin(wake_pin),
    .cpu_irq_mask(cpu_irq_mask), .direct_transition_evt(direct_transition_evt),
    .nmi_req(nmi_req), .ext_req_cpu(ext_req_cpu), .wakeup_req_cpu(wakeup_req_cpu),
    .direct_transition_req_cpu(direct_transition_req_cpu),
    .adc_ext_trigger(adc_ext_trigger), .irq(irq));

// ==== eiec_src_model.sv ====
// Model of the external interrupt and wakeup signal sources
`timescale 1ns/1ps
module eiec_src_model (
    // Clock
    input  wire logic clock,
    // Lines toward the block
    output logic       nmi_pin,
    output logic [3:0] ext_req_pin,
    output logic [5:0] wake_pin,
    output logic       direct_transition_evt
);
    // Idle high, so an idle source never looks like a falling edge
    logic [10:0] lvl_q = 11'h7FF;
    assign {nmi_pin, ext_req_pin, wake_pin} = lvl_q;
    initial direct_transition_evt = 1'b0;
    // Held well past the synchroniser and detector latency
    task automatic set_pin(input int k, input logic v);
        @(posedge clock);
        lvl_q[k] <= v;
        repeat (8) @(posedge clock);
    endtask
    task automatic dt_pulse();
        @(posedge clock);
        direct_transition_evt <= 1'b1;
        @(posedge clock);
        direct_transition_evt <= 1'b0;
    endtask
endmodule

// ==== ext_irq_edge_enable_ctrl_tb.sv ====
// Self-checking bench for the external interrupt front end
`timescale 1ns/1ps
module ext_irq_edge_enable_ctrl_tb import eiec_pkg::*; ();
    localparam int MODE = 'hB;
    localparam int EN   = 'h9;
    localparam int EMSK = 'h5;
    logic        clock = 1'b0;
    logic        rst_n, psel, penable, pwrite, cpu_irq_mask;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  mode, ext_req_cpu, ext_req_pin;
    logic [5:0]  wake_pin;
    logic        pready, pslverr, e, nmi_pin, dt_evt, nmi_req, wake_req, dt_req, adc_trg, irq;
    int          failures, compares, seed, nmi_cnt, adc_cnt, d, fl;
    int          exp_q[$];
    int          wm[3] = '{EDGE_NMI_WMASK, EDGE_WAKE_WMASK, INT_EN_WMASK};
    int          on[3] = '{EDGE_NMI_ONES, EDGE_WAKE_ONES, INT_EN_ONES};
    always #20 clock = ~clock;
    eiec_top u_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .ext_req_pin(ext_req_pin),
        .ext_req_pin_irq_mode(mode), .wake_pin(wake_pin), .cpu_irq_mask(cpu_irq_mask),
        .direct_transition_evt(dt_evt), .nmi_req(nmi_req), .ext_req_cpu(ext_req_cpu),
        .wakeup_req_cpu(wake_req), .direct_transition_req_cpu(dt_req),
        .adc_ext_trigger(adc_trg), .irq(irq));
    eiec_src_model u_src (.clock(clock), .nmi_pin(nmi_pin), .ext_req_pin(ext_req_pin),
        .wake_pin(wake_pin), .direct_transition_evt(dt_evt));
    always @(posedge clock) begin
        if (nmi_req === 1'b1)
            nmi_cnt++;
        if (adc_trg === 1'b1)
            adc_cnt++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int wd);
        apb(1'b1, a, 32'(wd));
    endtask
    task automatic rd_chk(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        check(r, 32'(exp));
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        failures++;
        print_verdict();
    end
    initial begin
        {failures, compares, nmi_cnt, adc_cnt, seed} = {32'h0, 32'h0, 32'h0, 32'h0, 32'd53};
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        mode = 4'(MODE);
        cpu_irq_mask = 1'b1;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int k = 0; k < 3; k++)
            rd_chk(8'(4 * k), on[k]);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(8'(4 * (i % 3)), d);
            exp_q.push_back((d & wm[i % 3]) | on[i % 3]);
            rd_chk(8'(4 * (i % 3)), exp_q.pop_front());
        end
        $display("Test registers done");
        foreach (wm[k]) begin
            apb(1'b0, (k == 0) ? 8'h01 : 8'h1C + 8'(4 * k), 32'h0);
            check({r[30:0], e}, 32'h1);
        end
        wr(OFS_EVT_MASK, EMSK);
        wr(OFS_INT_EN, EN);
        cpu_irq_mask <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = (1 << i) & $random(seed);
            wr(OFS_EDGE_NMI, d);
            fl = (MODE >> i) & 1;
            u_src.set_pin(6 + i, 1'b0);
            check(32'(ext_req_cpu), (d == 0 ? fl << i : 0) & EN);
            u_src.set_pin(6 + i, 1'b1);
            check(32'(ext_req_cpu), (fl << i) & EN);
            check(32'(irq), ((fl << i) & EMSK) != 0);
            rd_chk(OFS_REQ_FLAGS, fl << i);
            rd_chk(OFS_EVT_STATUS, fl << i);
            repeat (2) @(posedge clock);
            check(32'(irq), 0);
            cpu_irq_mask <= 1'b1;
            repeat (2) @(posedge clock);
            check(32'(ext_req_cpu), 0);
            wr(OFS_REQ_FLAGS, 0);
            cpu_irq_mask <= 1'b0;
            repeat (2) @(posedge clock);
            check(32'(ext_req_cpu), 0);
        end
        // Write-0 clear lands on the very edge at which the falling edge sets the flag
        fork
            u_src.set_pin(6, 1'b0);
            begin
                repeat (2) @(posedge clock);
                wr(OFS_REQ_FLAGS, 0);
            end
        join
        check(32'(ext_req_cpu), MODE & EN & 1);
        $display("Test request pins done");
        u_src.dt_pulse();
        repeat (3) @(posedge clock);
        check(32'(dt_req), 0);
        wr(OFS_INT_EN, 'hA9);
        repeat (2) @(posedge clock);
        check(32'(dt_req), 1);
        wr(OFS_EDGE_WAKE, 'h20);
        u_src.set_pin(5, 1'b0);
        check(32'({adc_cnt[7:0], wake_req}), 0);
        u_src.set_pin(5, 1'b1);
        check(32'({adc_cnt[7:0], wake_req}), 'h3);
        u_src.set_pin(0, 1'b0);
        rd_chk(OFS_WAKE_FLAGS, 'h21);
        $display("Test wakeup done");
        cpu_irq_mask <= 1'b1;
        wr(OFS_EDGE_NMI, 'h80);
        u_src.set_pin(10, 1'b0);
        check(32'(nmi_cnt), 0);
        u_src.set_pin(10, 1'b1);
        check(32'(nmi_cnt), 1);
        $display("Test nmi done");
        print_verdict();
    end
endmodule
